// file: hdl/ussu_pkg.sv
`default_nettype none
package ussu_pkg;

	// register indices and byte addresses
	localparam logic [7:0]  USSU_IDX_CTRL   = 8'h0D;
	localparam logic [7:0]  USSU_IDX_STAT   = 8'h0E;
	localparam logic [7:0]  USSU_IDX_DATA   = 8'h0F;
	localparam logic [7:0]  USSU_IDX_RXBUF  = 8'h10;
	localparam logic [9:0]  USSU_ADDR_CTRL  = {USSU_IDX_CTRL, 2'b00};
	localparam logic [9:0]  USSU_ADDR_STAT  = {USSU_IDX_STAT, 2'b00};
	localparam logic [9:0]  USSU_ADDR_DATA  = {USSU_IDX_DATA, 2'b00};
	localparam logic [9:0]  USSU_ADDR_RXBUF = {USSU_IDX_RXBUF, 2'b00};

	// control fields
	localparam int USSU_CTRL_SIE    = 7;
	localparam int USSU_CTRL_OIE    = 6;
	localparam int USSU_CTRL_WM_LO  = 4;
	localparam int USSU_CTRL_CS_LO  = 2;
	localparam int USSU_CTRL_CLK    = 1;
	localparam int USSU_CTRL_TC     = 0;

	// status fields
	localparam int USSU_STAT_SIF    = 7;
	localparam int USSU_STAT_OIF    = 6;
	localparam int USSU_STAT_PF     = 5;
	localparam int USSU_STAT_DC     = 4;

	// reset values
	localparam logic [7:0] USSU_CTRL_RST = 8'h00;
	localparam logic [7:0] USSU_STAT_RST = 8'h00;
	localparam logic [7:0] USSU_DATA_RST = 8'h00;
	localparam logic [7:0] USSU_RXBUF_RST = 8'h00;

	// wire modes
	localparam logic [1:0] USSU_WM_OFF   = 2'h0;
	localparam logic [1:0] USSU_WM_THREE = 2'h1;
	localparam logic [1:0] USSU_WM_TWO   = 2'h2;
	localparam logic [1:0] USSU_WM_TWOH  = 2'h3;

	// clock sources
	localparam logic [1:0] USSU_CS_SOFT  = 2'h0;
	localparam logic [1:0] USSU_CS_TIMER = 2'h1;
	localparam logic [1:0] USSU_CS_EXTP  = 2'h2;
	localparam logic [1:0] USSU_CS_EXTN  = 2'h3;

	localparam logic [3:0] USSU_CNT_MAX  = 4'hF;

endpackage
`default_nettype wire

// file: hdl/ussu_top.sv
`timescale 1ns/1ps
`default_nettype none
module ussu_top
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// system side
	input  wire logic        timer_match,
	input  wire logic        global_irq_enable,
	output logic             start_irq,
	output logic             overflow_irq,
	// pins
	input  wire logic        serial_in_pin,
	input  wire logic        serial_clock_pin,
	input  wire logic        data_dir_out,
	input  wire logic        clock_dir_out,
	input  wire logic        clock_port_bit,
	output logic             data_out,
	output logic             data_out_oe,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             scl_out,
	output logic             scl_oe
);
	import ussu_pkg::*;

	// -------------------------------------------------
	// state
	// -------------------------------------------------
	logic [7:0] serial_control;
	logic [7:0] shift_data;
	logic [7:0] receive_buffer;
	logic [3:0] clock_counter_value;
	logic       start_flag;
	logic       overflow_flag;
	logic       stop_flag;
	logic       latch_bit;

	logic       start_irq_enable;
	logic       overflow_irq_enable;
	logic [1:0] wire_mode_select;
	logic [1:0] clock_source_select;
	logic       clock_source_external;

	assign start_irq_enable      = serial_control[USSU_CTRL_SIE];
	assign overflow_irq_enable   = serial_control[USSU_CTRL_OIE];
	assign wire_mode_select      = serial_control[USSU_CTRL_WM_LO +: 2];
	assign clock_source_select   = serial_control[USSU_CTRL_CS_LO +: 2];
	assign clock_source_external = clock_source_select[1];

	// -------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------
	logic sda_meta;
	logic sda_sync;
	logic sda_prev;
	logic sck_meta;
	logic sck_sync;
	logic sck_prev;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
			sck_meta <= 1'b0;
			sck_sync <= 1'b0;
			sck_prev <= 1'b0;
		end
		else
		begin
			sda_meta <= serial_in_pin;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
			sck_meta <= serial_clock_pin;
			sck_sync <= sck_meta;
			sck_prev <= sck_sync;
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic sda_rise;
	logic sda_fall;

	assign sck_rise = sck_sync & ~sck_prev;
	assign sck_fall = ~sck_sync & sck_prev;
	assign sda_rise = sda_sync & ~sda_prev;
	assign sda_fall = ~sda_sync & sda_prev;

	// -------------------------------------------------
	// ahb-lite slave
	// -------------------------------------------------
	logic       dp_write;
	logic [9:0] dp_addr;

	function automatic logic [1:0] reg_sel(input logic [9:0] a);
		case (a)
			USSU_ADDR_CTRL:  reg_sel = 2'h0;
			USSU_ADDR_STAT:  reg_sel = 2'h1;
			USSU_ADDR_DATA:  reg_sel = 2'h2;
			USSU_ADDR_RXBUF: reg_sel = 2'h3;
			default:         reg_sel = 2'h0;
		endcase
	endfunction

	function automatic logic reg_hit(input logic [9:0] a);
		reg_hit = (a == USSU_ADDR_CTRL) || (a == USSU_ADDR_STAT) ||
			(a == USSU_ADDR_DATA) || (a == USSU_ADDR_RXBUF);
	endfunction

	logic addr_phase;
	logic upper_zero;

	assign upper_zero = (haddr[31:10] == 22'h0);
	assign addr_phase = hsel & hready & htrans[1];
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dp_write <= 1'b0;
			dp_addr  <= 10'h000;
		end
		else
		begin
			dp_write <= addr_phase & hwrite & upper_zero & reg_hit(haddr[9:0]);
			dp_addr  <= haddr[9:0];
		end
	end

	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_data;
	logic [7:0] wbyte;

	assign wbyte   = hwdata[7:0];
	assign wr_ctrl = dp_write & (reg_sel(dp_addr) == 2'h0);
	assign wr_stat = dp_write & (reg_sel(dp_addr) == 2'h1);
	assign wr_data = dp_write & (reg_sel(dp_addr) == 2'h2);

	logic output_collision;
	logic [7:0] status_view;

	assign output_collision = shift_data[7] ^ sda_sync;
	assign status_view = {start_flag, overflow_flag, stop_flag,
		output_collision, clock_counter_value};

	// read data taken in the address phase, shown in the data phase
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			hrdata <= 32'h0000_0000;
		else if (addr_phase & ~hwrite)
		begin
			if (!upper_zero || !reg_hit(haddr[9:0]))
				hrdata <= 32'h0000_0000;
			else
			begin
				case (reg_sel(haddr[9:0]))
					2'h0:    hrdata <= {24'h00_0000,
						serial_control[7:2], 2'b00};
					2'h1:    hrdata <= {24'h00_0000, status_view};
					2'h2:    hrdata <= {24'h00_0000, shift_data};
					default: hrdata <= {24'h00_0000, receive_buffer};
				endcase
			end
		end
	end

	// -------------------------------------------------
	// clock selection
	// -------------------------------------------------
	logic soft_strobe;
	logic toggle_write;
	logic shift_clk;
	logic count_clk;
	logic ext_edge;

	assign soft_strobe  = wr_ctrl & wbyte[USSU_CTRL_CLK];
	assign toggle_write = wr_ctrl & wbyte[USSU_CTRL_TC];
	assign ext_edge     = sck_rise | sck_fall;

	// shift clock per source; strobes act with the mode held before the write
	always_comb
	begin
		shift_clk = 1'b0;
		count_clk = 1'b0;
		case (clock_source_select)
			USSU_CS_SOFT:
			begin
				shift_clk = soft_strobe;
				count_clk = soft_strobe;
			end
			USSU_CS_TIMER:
			begin
				shift_clk = timer_match;
				count_clk = timer_match;
			end
			USSU_CS_EXTP:
			begin
				shift_clk = sck_rise;
				count_clk = ext_edge |
					(toggle_write & wbyte[USSU_CTRL_CLK]);
			end
			USSU_CS_EXTN:
			begin
				shift_clk = sck_fall;
				count_clk = ext_edge |
					(toggle_write & wbyte[USSU_CTRL_CLK]);
			end
			default:
			begin
				shift_clk = 1'b0;
				count_clk = 1'b0;
			end
		endcase
	end

	// -------------------------------------------------
	// control register
	// -------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			serial_control <= USSU_CTRL_RST;
		else if (wr_ctrl)
			serial_control <= {wbyte[7:2], 2'b00};
	end

	// -------------------------------------------------
	// shift register and receive buffer
	// -------------------------------------------------
	logic       wrap;
	logic [7:0] next_shift_data;

	assign wrap = count_clk & ~wr_stat &
		(clock_counter_value == USSU_CNT_MAX);

	always_comb
	begin
		if (wr_data)
			next_shift_data = wbyte;
		else if (shift_clk)
			next_shift_data = {shift_data[6:0], sda_sync};
		else
			next_shift_data = shift_data;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			shift_data <= USSU_DATA_RST;
		else
			shift_data <= next_shift_data;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			receive_buffer <= USSU_RXBUF_RST;
		else if (wrap)
			receive_buffer <= next_shift_data;
	end

	// -------------------------------------------------
	// clock counter
	// -------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			clock_counter_value <= USSU_STAT_RST[3:0];
		else if (wr_stat)
			clock_counter_value <= wbyte[3:0];
		else if (count_clk)
			clock_counter_value <= clock_counter_value + 4'h1;
	end

	// -------------------------------------------------
	// flags
	// -------------------------------------------------
	logic two_wire;
	logic start_cond;
	logic stop_cond;
	logic edge_start;

	assign two_wire   = wire_mode_select[1];
	assign start_cond = two_wire & sda_fall & sck_sync;
	assign stop_cond  = two_wire & sda_rise & sck_sync;
	assign edge_start = ~two_wire & clock_source_external &
		~(wr_ctrl & wbyte[USSU_CTRL_CLK]) & ext_edge;

	// set wins over a write-one clear
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			start_flag <= USSU_STAT_RST[USSU_STAT_SIF];
		else if (start_cond | edge_start)
			start_flag <= 1'b1;
		else if (wr_stat & wbyte[USSU_STAT_SIF])
			start_flag <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			overflow_flag <= USSU_STAT_RST[USSU_STAT_OIF];
		else if (wrap)
			overflow_flag <= 1'b1;
		else if (wr_stat & wbyte[USSU_STAT_OIF])
			overflow_flag <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			stop_flag <= USSU_STAT_RST[USSU_STAT_PF];
		else if (stop_cond)
			stop_flag <= 1'b1;
		else if (wr_stat & wbyte[USSU_STAT_PF])
			stop_flag <= 1'b0;
	end

	// level requests: an enable written over a pending flag fires at once
	assign start_irq    = start_flag & start_irq_enable &
		global_irq_enable;
	assign overflow_irq = overflow_flag & overflow_irq_enable &
		global_irq_enable;

	// -------------------------------------------------
	// output latch and pins
	// -------------------------------------------------
	logic latch_open;
	logic out_bit;

	// sample edge and change edge are opposite halves of the clock
	always_comb
	begin
		case (clock_source_select)
			USSU_CS_EXTP: latch_open = ~sck_sync;
			USSU_CS_EXTN: latch_open = sck_sync;
			default:      latch_open = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			latch_bit <= 1'b0;
		else if (latch_open)
			latch_bit <= next_shift_data[7];
	end

	// open latch passes a freshly written msb without waiting
	assign out_bit = latch_open ? shift_data[7] : latch_bit;

	logic clock_hold;

	assign clock_hold = two_wire & (start_flag |
		((wire_mode_select == USSU_WM_TWOH) & overflow_flag));

	always_comb
	begin
		data_out    = 1'b0;
		data_out_oe = 1'b0;
		sda_out     = 1'b0;
		sda_oe      = 1'b0;
		scl_out     = 1'b0;
		scl_oe      = 1'b0;
		case (wire_mode_select)
			USSU_WM_THREE:
			begin
				data_out    = out_bit;
				data_out_oe = data_dir_out;
			end
			USSU_WM_TWO,
			USSU_WM_TWOH:
			begin
				sda_oe = data_dir_out & ~out_bit;
				scl_oe = clock_dir_out &
					(~clock_port_bit | clock_hold);
			end
			default:
			begin
				data_out_oe = 1'b0;
			end
		endcase
	end

endmodule // ussu_top
`default_nettype wire

// file: testbench/ussu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ussu_checker
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        global_irq_enable,
	input wire logic        start_irq,
	input wire logic        overflow_irq,
	input wire logic        data_dir_out,
	input wire logic        clock_dir_out,
	input wire logic        data_out_oe,
	input wire logic        sda_oe,
	input wire logic        scl_oe
);
	import ussu_pkg::*;
	logic        wr_pend;
	logic [31:0] wr_addr;
	logic [7:0]  ctl;
	// ------------------------------------------------------------
	// shadow of the control register as written over the bus
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0;
			ctl     <= 8'h00;
		end
		else
		begin
			wr_pend <= hsel && hready && htrans[1] && hwrite;
			wr_addr <= haddr;
			if (wr_pend && wr_addr == {22'h0, USSU_ADDR_CTRL})
				ctl <= hwdata[7:0];
		end
	end
	default clocking dck @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_no_wait: assert property (hsel && htrans[1] |=> hreadyout [*2])
		else $error("wait state inserted");
	a_rdata_width: assert property (hsel && htrans[1] |=> hrdata[31:8] == 24'h0)
		else $error("read data above bit 7");
	a_start_gate: assert property (start_irq |-> global_irq_enable && ctl[7])
		else $error("start request without enables");
	a_ovf_gate: assert property (overflow_irq |-> global_irq_enable && ctl[6])
		else $error("overflow request without enables");
	a_off_quiet: assert property (ctl[5:4] == USSU_WM_OFF |-> !(data_out_oe || sda_oe || scl_oe))
		else $error("pin driven with wire mode off");
	a_dout_mode: assert property (data_out_oe |-> ctl[5:4] == USSU_WM_THREE && data_dir_out)
		else $error("data out enabled outside three-wire");
	a_sda_mode: assert property (sda_oe |-> ctl[5] && data_dir_out)
		else $error("data line pulled outside two-wire");
	a_scl_mode: assert property (scl_oe |-> ctl[5] && clock_dir_out)
		else $error("clock line pulled outside two-wire");
	cover property (start_irq);
	cover property (overflow_irq);
	cover property (scl_oe);
endmodule // ussu_checker
bind ussu_top ussu_checker u_checker
(
	.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hreadyout(hreadyout), .hrdata(hrdata),
	.global_irq_enable(global_irq_enable), .start_irq(start_irq),
	.overflow_irq(overflow_irq), .data_dir_out(data_dir_out),
	.clock_dir_out(clock_dir_out), .data_out_oe(data_out_oe),
	.sda_oe(sda_oe), .scl_oe(scl_oe)
);
`default_nettype wire

// file: testbench/ussu_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ussu_partner
(
	output logic sck,
	output logic sdi
);
	initial
	begin
		sck = 1'b0;
		sdi = 1'b0;
	end
	// ------------------------------------------------------------
	// serial master, 80 ns clock, still between frames
	// ------------------------------------------------------------
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			sdi = b[i];
			#20 sck = 1'b1;
			#40 sck = 1'b0;
			#20;
		end
		// released line shows the inverse of the last bit
		sdi = ~b[0];
	endtask
	task automatic start_cond();
		sdi = 1'b1;
		#40 sck = 1'b1;
		#40 sdi = 1'b0;
		#40;
	endtask
	task automatic stop_cond();
		sdi = 1'b0;
		#40 sdi = 1'b1;
		#40;
	endtask
endmodule // ussu_partner
`default_nettype wire

// file: testbench/tb_universal_serial_shift_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_universal_serial_shift_unit;
	import ussu_pkg::*;
	typedef struct {logic [9:0] a; logic [7:0] d; logic [7:0] e;} ussu_row_t;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        timer_match = 1'b0;
	logic        data_dir_out = 1'b1;
	wire         hreadyout;
	wire  [31:0] hrdata;
	wire         start_irq;
	wire         overflow_irq;
	wire         data_out;
	wire         data_out_oe;
	wire         sda_oe;
	wire         scl_oe;
	wire         sck;
	wire         sdi;
	wire         serial_in_pin = sda_oe ? 1'b0 : sdi;
	wire         serial_clock_pin = scl_oe ? 1'b0 : sck;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [7:0]  scratch;
	ussu_row_t   rows [6] = '{
		'{USSU_ADDR_CTRL, 8'hC0, 8'hC0}, '{USSU_ADDR_STAT, 8'h0A, 8'h0A},
		'{USSU_ADDR_DATA, 8'hA5, 8'hA5}, '{USSU_ADDR_RXBUF, 8'h55, 8'h00},
		'{10'h080, 8'hFF, 8'h00}, '{USSU_ADDR_STAT, 8'h00, 8'h10}};
	always #2 clk_sys = ~clk_sys;
	ussu_top u_dut
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.timer_match(timer_match), .global_irq_enable(1'b1),
		.start_irq(start_irq), .overflow_irq(overflow_irq),
		.serial_in_pin(serial_in_pin), .serial_clock_pin(serial_clock_pin),
		.data_dir_out(data_dir_out), .clock_dir_out(1'b1),
		.clock_port_bit(1'b1), .data_out(data_out),
		.data_out_oe(data_out_oe), .sda_out(), .sda_oe(sda_oe),
		.scl_out(), .scl_oe(scl_oe)
	);
	ussu_partner u_partner (.sck(sck), .sdi(sdi));
	// ------------------------------------------------------------
	// bus cycles and comparison
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic tm, output logic [7:0] q);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h0, a};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel        <= 1'b0;
		htrans      <= 2'h0;
		hwdata      <= {24'h0, d};
		timer_match <= tm;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
		timer_match <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, 1'b0, q);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, 1'b0, q);
		check(q & m, e);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++)
			rd(USSU_ADDR_CTRL + 10'(4 * i), 8'hFF, 8'h00);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, 8'hFF, rows[i].e);
		end
		$display("test registers done");
		wr(USSU_ADDR_CTRL, 8'h10);
		wr(USSU_ADDR_DATA, 8'h81);
		check({data_out_oe, data_out}, 2'b11);
		wr(USSU_ADDR_STAT, 8'h0F);
		wr(USSU_ADDR_CTRL, 8'h12);
		rd(USSU_ADDR_RXBUF, 8'hFF, 8'h02);
		rd(USSU_ADDR_STAT, 8'hFF, 8'h40);
		wr(USSU_ADDR_CTRL, 8'h50);
		check(overflow_irq, 1'b1);
		wr(USSU_ADDR_STAT, 8'h00);
		check(overflow_irq, 1'b1);
		wr(USSU_ADDR_STAT, 8'h40);
		check(overflow_irq, 1'b0);
		wr(USSU_ADDR_CTRL, 8'h14);
		bus(1'b1, USSU_ADDR_DATA, 8'h3C, 1'b1, scratch);
		rd(USSU_ADDR_DATA, 8'hFF, 8'h3C);
		@(posedge clk_sys) timer_match <= 1'b1;
		@(posedge clk_sys) timer_match <= 1'b0;
		rd(USSU_ADDR_DATA, 8'hFF, 8'h78);
		$display("test internal clocks done");
		wr(USSU_ADDR_STAT, 8'hE0);
		wr(USSU_ADDR_CTRL, 8'h88);
		u_partner.send(8'h5A);
		rd(USSU_ADDR_RXBUF, 8'hFF, 8'h5A);
		rd(USSU_ADDR_STAT, 8'hFF, 8'hD0);
		check(start_irq, 1'b1);
		wr(USSU_ADDR_CTRL, 8'h8B);
		rd(USSU_ADDR_STAT, 8'h0F, 8'h01);
		$display("test external clock done");
		wr(USSU_ADDR_STAT, 8'hE0);
		@(posedge clk_sys) data_dir_out <= 1'b0;
		wr(USSU_ADDR_CTRL, 8'hA8);
		u_partner.start_cond();
		check({start_irq, scl_oe}, 2'b11);
		wr(USSU_ADDR_STAT, 8'h80);
		check({start_irq, scl_oe}, 2'b00);
		u_partner.stop_cond();
		rd(USSU_ADDR_STAT, 8'hA0, 8'h20);
		check(start_irq, 1'b0);
		@(posedge clk_sys) data_dir_out <= 1'b1;
		wr(USSU_ADDR_DATA, 8'h00);
		check(sda_oe, 1'b0);
		wr(USSU_ADDR_CTRL, 8'hA0);
		check(sda_oe, 1'b1);
		repeat (4) @(posedge clk_sys);
		#1;
		check(start_irq, 1'b1);
		wr(USSU_ADDR_STAT, 8'h8F);
		wr(USSU_ADDR_CTRL, 8'h32);
		check(scl_oe, 1'b1);
		wr(USSU_ADDR_STAT, 8'h40);
		check(scl_oe, 1'b0);
		$display("test two-wire done");
		end_of_test();
	end
endmodule // tb_universal_serial_shift_unit
`default_nettype wire
